// [src/pmcm_pkg.sv]
// Constants, encodings and carrier types of the power mode and clock manager
package pmcm_pkg;
    // Clock rates
    localparam int MCLK_HZ  = 20_000_000;
    localparam int HF_HZ    = 48_000_000;
    localparam int MF_HZ    = 2_000_000;
    localparam int LF_MHZ_X = 32_768_000;  // Low clock in millihertz
    localparam int MF_DIV   = MCLK_HZ / MF_HZ;
    localparam int DIV_W    = 4;

    // Register map, byte addresses
    localparam int        AW     = 5;
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_CLK  = 5'h04;
    localparam logic [4:0] A_STAT = 5'h08;
    localparam logic [4:0] A_WAKE = 5'h0C;
    localparam logic [4:0] A_PAD  = 5'h10;
    localparam logic [4:0] A_WDOG = 5'h14;

    // Control field positions
    localparam int F_REQ_LO = 0;
    localparam int F_GO     = 2;
    localparam int F_WD_EN  = 3;
    localparam int F_WD_KCK = 4;
    // Clock select field positions
    localparam int F_HF_X   = 0;
    localparam int F_LF_LO  = 1;
    localparam int F_LF_OUT = 3;
    localparam int F_RADIO  = 4;

    typedef enum logic [1:0] {M_ACT = 2'h0, M_IDLE = 2'h1, M_STBY = 2'h2, M_SHDN = 2'h3} mode_t;
    typedef enum logic [1:0] {C_POR = 2'h0, C_PIN = 2'h1, C_PADWAKE = 2'h2} cause_t;
    typedef enum logic [1:0] {LF_RC = 2'h0, LF_XTAL = 2'h1, LF_PAD = 2'h2} lf_src_t;
    // Gray along active, gate, standby, wake, back to active
    typedef enum logic [2:0] {
        S_ACT  = 3'h0,
        S_GATE = 3'h1,
        S_STBY = 3'h3,
        S_WAKE = 3'h2,
        S_IDLE = 3'h6,
        S_SHDN = 3'h7
    } state_t;

    // Clock source selection carried to the clock tree
    typedef struct packed {
        logic    hf_xtal;
        lf_src_t lf_src;
        logic    lf_out;
        logic    radio;
    } clk_cfg_t;

    localparam clk_cfg_t CLK_RST = '{hf_xtal: 1'b0, lf_src: LF_RC, lf_out: 1'b0, radio: 1'b0};
endpackage

// [src/power_mode_clock_manager.sv]
// Power mode sequencer, clock gating, pad latching and reset cause record
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module power_mode_clock_manager
    import pmcm_pkg::*;
#(
    parameter int NPAD = 8,
    parameter int WD_W = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             reset_pin_n,
    // Register port
    input  wire logic [AW-1:0]    addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output logic      [31:0]      rdata,
    // Wake sources
    input  wire logic             irq_any,
    input  wire logic             rtc_event,
    input  wire logic             sc_event,
    input  wire logic             ext_wake,
    input  wire logic [NPAD-1:0]  pad_in,
    // Pads and power
    output logic      [NPAD-1:0]  pad_out,
    output logic                  pad_hold,
    output logic                  always_on_domain,
    output logic                  sc_power,
    output logic                  rtc_run,
    // Clock control
    output logic                  cpu_clk_en,
    output logic                  mem_clk_en,
    output logic                  periph_clk_en,
    output logic                  main_fast_clock_en,
    output logic                  medium_speed_clock_en,
    output logic                  low_freq_clock_en,
    output clk_cfg_t              clk_sel,
    output logic                  lf_pad_drive,
    output logic                  radio_en,
    output logic                  radio_timer_sync,
    output logic                  retain_restore,
    output logic [1:0]            mode
);
    typedef struct packed {
        state_t            st;
        mode_t             tgt;
        cause_t            cause;
        clk_cfg_t          clk;
        logic              wd_en;
        logic [WD_W-1:0]   wd_cnt;
        logic [NPAD-1:0]   wake_mask;
        logic [NPAD-1:0]   pad_val;
        logic [NPAD-1:0]   pad_lat;
        logic              hold;
        logic [DIV_W-1:0]  div;
        logic              tick;
        logic [NPAD-1:0]   pad_s1;
        logic [NPAD-1:0]   pad_s2;
        logic [2:0]        wk_s1;
        logic [2:0]        wk_s2;
        logic              rp_s1;
        logic              rp_s2;
        logic [31:0]       rdata;
        logic [8:0]        oen;
        logic              sync_p;
        logic              rest_p;
        logic [1:0]        mode_q;
        logic              lf_drv;
        logic              radio_q;
    } st_t;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MF_DIV - 1);
    // Enable bits from bit 0: cpu, mem, always-on, periph, fast, medium, low, rtc, controller
    localparam logic [8:0] OEN_ACT  = 9'h1FF;
    localparam logic [8:0] OEN_IDLE = 9'h1FC;
    // Standby keeps always-on, low clock, real-time clock and the controller
    localparam logic [8:0] OEN_STBY = 9'h1C4;

    st_t state_reg;
    st_t state_next;
    st_t st_rst;
    logic pad_wake;
    logic wk_any;

    // Power-on value; also the state after a pin or pad-wake reset
    always_comb begin
        st_rst        = '0;
        st_rst.st     = S_ACT;
        st_rst.tgt    = M_ACT;
        st_rst.cause  = C_POR;
        st_rst.clk    = CLK_RST;
        st_rst.oen    = OEN_ACT;
        st_rst.pad_s1 = '0;
        st_rst.rp_s1  = 1'b1;
        st_rst.rp_s2  = 1'b1;
    end

    // Shutdown wake compare uses the synchronised pad, never the first stage
    assign pad_wake = |((state_reg.pad_s2 ^ state_reg.pad_lat) & state_reg.wake_mask);
    assign wk_any   = |state_reg.wk_s2;

    always_comb begin
        state_next = state_reg;
        state_next.sync_p = 1'b0;
        state_next.rest_p = 1'b0;
        state_next.rdata  = '0;
        // Two-flop synchronisers for pins
        state_next.pad_s1 = pad_in;
        state_next.pad_s2 = state_reg.pad_s1;
        state_next.wk_s1  = {ext_wake, rtc_event, sc_event};
        state_next.wk_s2  = state_reg.wk_s1;
        state_next.rp_s1  = reset_pin_n;
        state_next.rp_s2  = state_reg.rp_s1;
        if (state_reg.wd_en && (state_reg.st == S_ACT || state_reg.st == S_IDLE)) begin
            state_next.wd_cnt = state_reg.wd_cnt + 1'b1;
        end
        // Register writes, only while the processor runs
        if (wr_en && state_reg.st == S_ACT) begin
            case (addr)
                A_CTRL: begin
                    state_next.wd_en = state_reg.wd_en | wdata[F_WD_EN];  // Cannot stop once on
                    if (wdata[F_WD_KCK]) begin
                        state_next.wd_cnt = '0;
                    end
                    if (wdata[F_GO]) begin
                        state_next.tgt = mode_t'(wdata[F_REQ_LO+:2]);
                        if (mode_t'(wdata[F_REQ_LO+:2]) == M_IDLE) begin
                            state_next.st = S_IDLE;
                        end else if (mode_t'(wdata[F_REQ_LO+:2]) != M_ACT) begin
                            state_next.st = S_GATE;
                        end
                    end
                end
                // Fast source RC or crystal; low source select
                A_CLK: begin
                    state_next.clk.hf_xtal = wdata[F_HF_X];
                    state_next.clk.radio   = wdata[F_RADIO];
                    if (wdata[F_LF_LO+:2] != 2'h3) begin
                        state_next.clk.lf_src = lf_src_t'(wdata[F_LF_LO+:2]);
                    end
                    state_next.clk.lf_out = wdata[F_LF_OUT];
                end
                A_WAKE: state_next.wake_mask = wdata[NPAD-1:0];
                A_PAD:  state_next.pad_val   = wdata[NPAD-1:0];
                default: begin
                end
            endcase
        end
        // Register reads, data valid the following cycle
        if (rd_en) begin
            case (addr)
                A_CTRL: state_next.rdata = {27'h0, 1'b0, state_reg.wd_en, 1'b0, state_reg.tgt};
                // Same bit layout as the write, not the carrier's packing order
                A_CLK:  state_next.rdata = {27'h0, state_reg.clk.radio, state_reg.clk.lf_out,
                                            state_reg.clk.lf_src, state_reg.clk.hf_xtal};
                A_STAT: state_next.rdata = {26'h0, radio_en, state_reg.cause, state_reg.st};
                A_WAKE: state_next.rdata = 32'(state_reg.wake_mask);
                A_PAD:  state_next.rdata = 32'(state_reg.pad_val);
                A_WDOG: state_next.rdata = 32'(state_reg.wd_cnt);
                default: state_next.rdata = '0;
            endcase
        end
        // Pads follow software value unless held
        if (!state_reg.hold) begin
            state_next.pad_lat = state_reg.pad_val;
        end
        // Power mode sequencer
        case (state_reg.st)
            S_ACT: begin
                // Gate on the request edge itself, so the first low-power cycle is already dark
                if (state_next.st == S_IDLE) begin
                    state_next.oen = OEN_IDLE;
                end else if (state_next.st == S_GATE) begin
                    state_next.oen  = OEN_IDLE;
                    state_next.hold = 1'b1;
                end else begin
                    state_next.oen  = OEN_ACT;
                    state_next.hold = 1'b0;
                end
            end
            // Processor and memory clocks gated; interrupt wakes
            S_IDLE: begin
                state_next.oen = OEN_IDLE;
                if (irq_any) begin
                    state_next.st  = S_ACT;
                    state_next.tgt = M_ACT;
                    state_next.oen = OEN_ACT;
                end
            end
            // Gate clocks and latch pads, then commit on a medium tick
            S_GATE: begin
                state_next.oen  = OEN_IDLE;
                // Latch takes the value present before entry
                state_next.hold = 1'b1;
                if (state_reg.tick) begin
                    if (state_reg.tgt == M_SHDN) begin
                        state_next.st  = S_SHDN;
                        state_next.oen = '0;
                    end else begin
                        // Only always-on, controller, low clock and real-time clock stay
                        state_next.st     = S_STBY;
                        state_next.oen    = OEN_STBY;
                        state_next.sync_p = 1'b1;
                    end
                end
            end
            // Pads stay held; only listed wake sources leave
            S_STBY: begin
                if (wk_any) begin
                    state_next.st = S_WAKE;
                end
            end
            // Restore retention and resume, with radio timer resync
            S_WAKE: begin
                if (state_reg.tick) begin
                    state_next.st     = S_ACT;
                    state_next.tgt    = M_ACT;
                    state_next.oen    = OEN_ACT;
                    state_next.hold   = 1'b0;
                    state_next.sync_p = 1'b1;
                    state_next.rest_p = 1'b1;
                end
            end
            // Wake pad change resets; all but pad latch and divider lost
            S_SHDN: begin
                if (pad_wake) begin
                    state_next         = st_rst;
                    state_next.cause   = C_PADWAKE;
                    state_next.pad_lat = state_reg.pad_lat;
                    state_next.pad_s1  = pad_in;
                end
            end
            default: state_next.st = S_ACT;
        endcase
        // Reset pin restarts the block and records itself
        if (!state_reg.rp_s2) begin
            state_next        = st_rst;
            state_next.cause  = C_PIN;
            state_next.rp_s1  = reset_pin_n;
            // Keep the pin synchroniser moving so its release is seen two edges later
            state_next.rp_s2  = state_reg.rp_s1;
            state_next.pad_s1 = pad_in;
        end
        // Medium clock enable pulse from divider; placed after the block resets
        // since the divider is clock infrastructure and its spacing must survive them
        state_next.tick = 1'b0;
        if (state_reg.div == DIV_LAST) begin
            state_next.div  = '0;
            state_next.tick = 1'b1;
        end else begin
            state_next.div = state_reg.div + 1'b1;
        end
        // Decodes taken from the next state, so these outputs leave flip-flops with no lag
        // Low clock to pad only from crystal or RC
        state_next.lf_drv  = state_next.clk.lf_out & (state_next.clk.lf_src != LF_PAD) & state_next.oen[6];
        // Radio only runs from the fast crystal
        state_next.radio_q = state_next.clk.radio & state_next.clk.hf_xtal & state_next.oen[4];
        case (state_next.st)
            S_IDLE:  state_next.mode_q = M_IDLE;
            S_STBY:  state_next.mode_q = M_STBY;
            S_SHDN:  state_next.mode_q = M_SHDN;
            default: state_next.mode_q = M_ACT;
        endcase
    end

    // Single state register; reset takes constants only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '{st: S_ACT, tgt: M_ACT, cause: C_POR, clk: CLK_RST, oen: OEN_ACT,
                           rp_s1: 1'b1, rp_s2: 1'b1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign rdata                 = state_reg.rdata;
    assign pad_out               = state_reg.pad_lat;
    assign pad_hold              = state_reg.hold;
    assign cpu_clk_en            = state_reg.oen[0];
    assign mem_clk_en            = state_reg.oen[1];
    // Always-on stays up in standby, falls in shutdown
    assign always_on_domain      = state_reg.oen[2];
    assign periph_clk_en         = state_reg.oen[3];
    assign main_fast_clock_en    = state_reg.oen[4];
    // Medium clock has no source select, only an enable
    assign medium_speed_clock_en = state_reg.oen[5];
    assign low_freq_clock_en     = state_reg.oen[6];
    // Real-time clock runs everywhere but shutdown
    assign rtc_run               = state_reg.oen[7];
    assign sc_power              = state_reg.oen[8];
    assign clk_sel               = state_reg.clk;
    // Low clock to pad only from crystal or RC; radio needs crystal
    assign lf_pad_drive          = state_reg.lf_drv;
    assign radio_en              = state_reg.radio_q;
    assign radio_timer_sync      = state_reg.sync_p;
    assign retain_restore        = state_reg.rest_p;
    assign mode                  = state_reg.mode_q;

    // Checks on the sequencer
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_idle_gating: assert property ((state_reg.st == S_IDLE && !irq_any) |=> !cpu_clk_en && periph_clk_en)
        else $error("idle clocks wrong");
    chk_idle_wake: assert property ((state_reg.st == S_IDLE && irq_any && state_reg.rp_s2) |=> cpu_clk_en)
        else $error("idle did not wake on interrupt");
    chk_standby_power: assert property ($rose(state_reg.st == S_STBY) |-> always_on_domain && !cpu_clk_en
                                        && !periph_clk_en && !main_fast_clock_en)
        else $error("standby powers wrong domains");
    chk_standby_stay: assert property ((state_reg.st == S_STBY && !wk_any && state_reg.rp_s2)
                                       |=> state_reg.st == S_STBY)
        else $error("standby left without wake");
    chk_wake_restore: assert property ((state_reg.st == S_WAKE && state_reg.tick && state_reg.rp_s2)
                                       |=> retain_restore && radio_timer_sync && cpu_clk_en)
        else $error("wake missed restore");
    chk_pad_hold: assert property ((pad_hold && state_reg.rp_s2 && state_reg.st != S_SHDN && state_reg.st != S_ACT
                                   && state_reg.st != S_WAKE) |=> $stable(pad_out))
        else $error("held pad moved");
    chk_shdn_off: assert property ((state_reg.st == S_SHDN) |-> !always_on_domain && !sc_power && !rtc_run)
        else $error("shutdown left power on");
    chk_pad_wake: assert property ((state_reg.st == S_SHDN && pad_wake && state_reg.rp_s2)
                                   |=> state_reg.cause == C_PADWAKE && state_reg.st == S_ACT
                                   && $stable(pad_out))
        else $error("pad wake reset wrong");
    chk_pin_cause: assert property (!state_reg.rp_s2 |=> state_reg.cause == C_PIN && state_reg.wake_mask == '0)
        else $error("pin reset not recorded");
    chk_radio_xtal: assert property (radio_en |-> clk_sel.hf_xtal)
        else $error("radio on without crystal");
    chk_mf_tick: assert property (state_reg.tick |=> !state_reg.tick [*8] ##1 !state_reg.tick
                                  ##1 state_reg.tick)
        else $error("medium tick spacing wrong");
    chk_lf_drive: assert property (lf_pad_drive |-> clk_sel.lf_src != LF_PAD && low_freq_clock_en)
        else $error("low clock driven to pad from pad source");
    chk_wdog_pause: assert property ((state_reg.st == S_STBY && state_reg.rp_s2) |=> $stable(state_reg.wd_cnt))
        else $error("watchdog ran in standby");
    chk_gate_commit: assert property ((state_reg.st == S_GATE) |-> ##[1:10] (state_reg.st != S_GATE)
                                      && pad_hold)
        else $error("gate did not commit");

    cov_idle_trip: cover property (state_reg.st == S_IDLE ##[1:50] state_reg.st == S_ACT);
    cov_standby_trip: cover property (state_reg.st == S_STBY ##[1:50] retain_restore);
    cov_shdn_wake: cover property (state_reg.st == S_SHDN ##1 state_reg.cause == C_PADWAKE);
    cov_gate_shdn: cover property (state_reg.st == S_GATE ##[1:10] state_reg.st == S_SHDN);
endmodule

`default_nettype wire

// [test/power_mode_clock_manager_tb_top.sv]
// Self-checking testbench of the power mode and clock manager
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module power_mode_clock_manager_tb_top;
    import pmcm_pkg::*;
    localparam int NPAD = 8;
    logic             mclk        = 1'b0;
    logic             reset_n     = 1'b0;
    logic             reset_pin_n = 1'b1;
    logic             wr_en       = 1'b0;
    logic             rd_en       = 1'b0;
    logic             irq_any     = 1'b0;
    logic             rtc_event   = 1'b0;
    logic             sc_event    = 1'b0;
    logic             ext_wake    = 1'b0;
    logic [AW-1:0]    addr        = '0;
    logic [31:0]      wdata       = '0;
    logic [NPAD-1:0]  pad_in      = '0;
    logic [31:0]      rdata, d, w1;
    logic [NPAD-1:0]  pad_out;
    logic             pad_hold, always_on_domain, sc_power, rtc_run, cpu_clk_en, mem_clk_en, periph_clk_en;
    logic             main_fast_clock_en, medium_speed_clock_en, low_freq_clock_en, lf_pad_drive, radio_en;
    logic             radio_timer_sync, retain_restore;
    logic [1:0]       mode;
    clk_cfg_t         clk_sel;
    int               n_errors = 0, samples_checked = 0, n_restore = 0, n_sync = 0, i, j;
    // Power and clock enables gathered so each state is one compare
    wire logic [8:0]  en_vec = {cpu_clk_en, mem_clk_en, periph_clk_en, main_fast_clock_en, medium_speed_clock_en,
                                low_freq_clock_en, always_on_domain, sc_power, rtc_run};

    power_mode_clock_manager #(.NPAD(NPAD), .WD_W(16)) dut (
        .mclk(mclk), .reset_n(reset_n), .reset_pin_n(reset_pin_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .irq_any(irq_any), .rtc_event(rtc_event), .sc_event(sc_event),
        .ext_wake(ext_wake), .pad_in(pad_in), .pad_out(pad_out), .pad_hold(pad_hold),
        .always_on_domain(always_on_domain), .sc_power(sc_power), .rtc_run(rtc_run), .cpu_clk_en(cpu_clk_en),
        .mem_clk_en(mem_clk_en), .periph_clk_en(periph_clk_en), .main_fast_clock_en(main_fast_clock_en),
        .medium_speed_clock_en(medium_speed_clock_en), .low_freq_clock_en(low_freq_clock_en),
        .clk_sel(clk_sel), .lf_pad_drive(lf_pad_drive), .radio_en(radio_en),
        .radio_timer_sync(radio_timer_sync), .retain_restore(retain_restore), .mode(mode));

    // 20 MHz clock
    always #25 mclk = ~mclk;

    // Pulses are counted on the falling edge, clear of the launching edge
    always @(negedge mclk) begin
        if (retain_restore === 1'b1) n_restore++;
        if (radio_timer_sync === 1'b1) n_sync++;
    end

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Register write: one strobe cycle, effect visible after the sampling edge
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask

    // Register read: data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic set_wake(input logic [2:0] v);
        @(posedge mclk);
        {ext_wake, rtc_event, sc_event} <= v;
    endtask

    // Bounded wait, since gate and wake last up to one medium tick
    task automatic wait_mode(input logic [1:0] m);
        int k;
        k = 0;
        while (mode !== m && k < 60) begin
            cycles(1);
            k++;
        end
        `CHK(mode, m)
    endtask

    task automatic done(input string s);
        $display("test %s finished, %0d mismatches so far", s, n_errors);
    endtask

    task automatic results;
        $display("checks made %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 1000 cycles, allow 4000
    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        cycles(1);
        `CHK(en_vec, 9'h1FF)
        `CHK({pad_hold, mode, radio_en, lf_pad_drive}, 5'h00)
        rd(A_STAT, d);
        `CHK(d[4:0], 5'h00)
        done("reset");

        wr(A_CLK, 32'h11);
        `CHK({clk_sel.hf_xtal, clk_sel.radio, radio_en}, 3'h7)
        rd(A_STAT, d);
        `CHK(d[5], 1'b1)
        wr(A_CLK, 32'h10);
        `CHK(radio_en, 1'b0)
        for (i = 0; i < 3; i++) begin
            wr(A_CLK, 32'h09 | (i << 1));
            `CHK(clk_sel.lf_src, lf_src_t'(i))
            `CHK(lf_pad_drive, (i != 2))
        end
        // Source code 3 is reserved and must leave the pad source in place
        wr(A_CLK, 32'h0F);
        rd(A_CLK, d);
        `CHK(d[2:1], 2'h2)
        `CHK(medium_speed_clock_en, 1'b1)
        wr(A_CLK, 32'h01);
        done("clock select");

        wr(A_PAD, 32'h5A);
        wr(A_CTRL, 32'h05);
        `CHK(mode, M_IDLE)
        `CHK(en_vec, 9'h07F)
        wr(A_PAD, 32'hFF);
        `CHK(pad_out, 8'h5A)
        set_wake(3'b111);
        cycles(4);
        `CHK(mode, M_IDLE)
        set_wake(3'b000);
        @(posedge mclk);
        irq_any <= 1'b1;
        cycles(1);
        `CHK(mode, M_ACT)
        `CHK(en_vec, 9'h1FF)
        @(posedge mclk);
        irq_any <= 1'b0;
        done("idle");

        wr(A_CTRL, 32'h08);
        rd(A_WDOG, w1);
        rd(A_WDOG, d);
        `CHK(d != w1, 1'b1)
        // One pass per standby wake source
        for (i = 0; i < 3; i++) begin
            n_restore = 0;
            n_sync = 0;
            wr(A_CTRL, 32'h06);
            `CHK({pad_hold, cpu_clk_en, mem_clk_en}, 3'b100)
            wait_mode(M_STBY);
            `CHK(en_vec, 9'h00F)
            `CHK({pad_hold, pad_out}, {1'b1, 8'h5A})
            rd(A_WDOG, w1);
            @(posedge mclk);
            irq_any <= 1'b1;
            cycles(4);
            `CHK(mode, M_STBY)
            @(posedge mclk);
            irq_any <= 1'b0;
            rd(A_WDOG, d);
            `CHK(d, w1)
            set_wake(3'b100 >> i);
            for (j = 0; j < 40 && n_restore == 0; j++) cycles(1);
            set_wake(3'b000);
            cycles(1);
            `CHK({en_vec, pad_hold, mode}, {9'h1FF, 1'b0, M_ACT})
            `CHK({clk_sel.hf_xtal, n_restore[3:0], n_sync[3:0]}, 9'h112)
        end
        done("standby");

        @(posedge mclk);
        pad_in <= 8'hA5;
        wr(A_PAD, 32'hA5);
        wr(A_WAKE, 32'h01);
        wr(A_CTRL, 32'h07);
        wait_mode(M_SHDN);
        `CHK({en_vec, pad_hold, pad_out}, {9'h000, 1'b1, 8'hA5})
        @(posedge mclk);
        pad_in <= 8'hA7;
        cycles(5);
        `CHK({mode, pad_out}, {M_SHDN, 8'hA5})
        @(posedge mclk);
        pad_in <= 8'hA6;
        wait_mode(M_ACT);
        rd(A_STAT, d);
        `CHK(d[4:0], 5'h10)
        rd(A_CLK, d);
        `CHK(d, 32'h0)
        done("shutdown");

        @(posedge mclk);
        reset_pin_n <= 1'b0;
        cycles(4);
        @(posedge mclk);
        reset_pin_n <= 1'b1;
        cycles(3);
        rd(A_STAT, d);
        `CHK(d[4:3], 2'h1)
        done("reset pin");
        results();
    end
endmodule
`default_nettype wire
